// *** verilog/sppc_cfg.svh ***
`ifndef SPPC_CFG_SVH
`define SPPC_CFG_SVH

// ****************************************************************
// link command codes
// ****************************************************************
`define SPPC_CMD_TERM       8'hf1
`define SPPC_CMD_DATA_MODE  8'he1
`define SPPC_CMD_CMD_MODE   8'he3
`define SPPC_PULSE_MASK     8'hed
`define SPPC_PULSE_CODE     8'hed
`define SPPC_BIT_MASK       8'he1
`define SPPC_BIT_CODE       8'h81

// ****************************************************************
// command fields and response codes
// ****************************************************************
`define SPPC_ARM_BIT        1
`define SPPC_VPP_BIT        4
`define SPPC_BIT_VAL_BIT    4
`define SPPC_PULSE_RSP_MASK 8'hfc
`define SPPC_SPU_RSP        8'hec

// ****************************************************************
// pullup duration counter
// ****************************************************************
`define SPPC_DUR_W          24
`define SPPC_DUR_RST        24'h000100

// ****************************************************************
// host register map (byte addresses)
// ****************************************************************
`define SPPC_ADR_W          8
`define SPPC_REG_CTRL       8'h00
`define SPPC_REG_DUR        8'h04
`define SPPC_REG_TX         8'h08
`define SPPC_REG_RX         8'h0c
`define SPPC_REG_STAT       8'h10
`define SPPC_REG_MASK       8'h14
`define SPPC_STAT_W         3
`define SPPC_ST_RSP         0
`define SPPC_ST_REFUSED     1
`define SPPC_ST_TX_DONE     2
`define SPPC_BUSY_BIT       8

`endif

// *** verilog/sppc_pkg.sv ***
`default_nettype none
`include "sppc_cfg.svh"

package sppc_pkg;

    typedef enum logic [1:0] {
        SPPC_DUR_PREDEF,
        SPPC_DUR_DYNAMIC,
        SPPC_DUR_INFINITE
    } sppc_dur_t;

    typedef enum logic [1:0] {
        SPPC_ST_IDLE,
        SPPC_ST_XFER,
        SPPC_ST_SBIT,
        SPPC_ST_PULSE
    } sppc_state_t;

    function automatic logic sppc_is_pulse(input logic [7:0] b);
        return (b & `SPPC_PULSE_MASK) == `SPPC_PULSE_CODE;
    endfunction

    function automatic logic sppc_is_bit(input logic [7:0] b);
        return (b & `SPPC_BIT_MASK) == `SPPC_BIT_CODE;
    endfunction

endpackage

`default_nettype wire

// *** verilog/sppc_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sppc_cfg.svh"

interface sppc_link_if;
    import sppc_pkg::*;

    logic                   h2d_valid;
    logic                   h2d_ready;
    logic [7:0]             h2d_data;
    logic                   d2h_valid;
    logic [7:0]             d2h_data;
    sppc_dur_t              dur_sel;
    logic [`SPPC_DUR_W-1:0] dur_cnt;

    modport dev (
        input  h2d_valid,
        input  h2d_data,
        input  dur_sel,
        input  dur_cnt,
        output h2d_ready,
        output d2h_valid,
        output d2h_data
    );

    modport host (
        output h2d_valid,
        output h2d_data,
        output dur_sel,
        output dur_cnt,
        input  h2d_ready,
        input  d2h_valid,
        input  d2h_data
    );
endinterface

`default_nettype wire

// *** verilog/sppc_dur_tmr.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sppc_cfg.svh"

module sppc_dur_tmr #(
    parameter int DUR_W = `SPPC_DUR_W
) (
    input  wire logic                i_clock,
    input  wire logic                i_rst_b,
    input  wire logic                i_start,
    input  wire logic                i_stop,
    input  wire sppc_pkg::sppc_dur_t i_dur_sel,
    input  wire logic [DUR_W-1:0]    i_dur_cnt,
    input  wire logic                i_load_low,
    output logic                     o_done
);
    import sppc_pkg::*;

    if (DUR_W < 2) begin : g_chk
        $error("sppc_dur_tmr: DUR_W must be at least 2");
    end

    logic             ld1_q;
    logic             ld2_q;
    logic             ld3_q;
    logic             load_low_q;
    logic             active_q;
    sppc_dur_t        sel_q;
    logic [DUR_W-1:0] cnt_q;

    // ****************************************************************
    // load sensor pin synchroniser
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ld1_q      <= 1'b0;
            ld2_q      <= 1'b0;
            ld3_q      <= 1'b0;
            load_low_q <= 1'b0;
        end else begin
            ld1_q <= i_load_low;
            ld2_q <= ld1_q;
            ld3_q <= ld2_q;
            // change only once two stages agree, so a glitch is not taken
            if (ld2_q == ld3_q) begin
                load_low_q <= ld3_q;
            end
        end
    end

    // ****************************************************************
    // duration counting
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            active_q <= 1'b0;
            sel_q    <= SPPC_DUR_PREDEF;
            cnt_q    <= '0;
        end else if (i_start) begin
            active_q <= 1'b1;
            sel_q    <= i_dur_sel;
            cnt_q    <= i_dur_cnt;
        end else if (i_stop || o_done) begin
            active_q <= 1'b0;
        end else if (active_q && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // infinite never ends here; only the owner's stop ends it
    always_comb begin
        case (sel_q)
            SPPC_DUR_PREDEF:  o_done = active_q && (cnt_q <= DUR_W'(1));
            SPPC_DUR_DYNAMIC: o_done = active_q && load_low_q;
            default:          o_done = 1'b0;
        endcase
    end
endmodule

`default_nettype wire

// *** verilog/sppc_dev_end.sv ***
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sppc_cfg.svh"

// Summary of operation
// - pulse command byte starts pullup or 12V
// - host ends infinite pulse; termination gets no reply
// - termination ends pulse, then pulse response
// - pulse command bit 1 arms or disarms pullup
// - armed data mode pulls up after every byte
// - eighth slot done: pullup and data response together
// - armed pullup end sends pulse response after data
// - host limits duration before using armed pullup
// - infinite armed data pullup locks until reset
// - host avoids dynamic duration with armed pullup
// - single-bit command bit 1 requests pullup directly
// - single-bit stays in command mode, any duration
// - single-bit: response at slot end, pulse response later
// - infinite single-bit pullup ended by termination byte
// - dynamic duration holds pullup while load needs it
// - one-byte receive buffer during bus activity
// - host must not overrun the single buffer

module sppc_dev_end #(
    parameter int DUR_W = `SPPC_DUR_W
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    sppc_link_if.dev        link,
    output logic            o_bus_req,
    output logic            o_bus_single,
    output logic [7:0]      o_bus_wdata,
    input  wire logic       i_bus_done,
    input  wire logic [7:0] i_bus_rdata,
    input  wire logic       i_load_low,
    output logic            o_spu_en,
    output logic            o_vpp_en,
    output logic            o_data_mode,
    output logic            o_armed
);
    import sppc_pkg::*;

    if (DUR_W != `SPPC_DUR_W) begin : g_chk
        $error("sppc_dev_end: DUR_W must match the link duration width");
    end

    logic        buf_v_q;
    logic [7:0]  buf_q;
    sppc_state_t state_q;
    logic        data_mode_q;
    logic        armed_q;
    logic [7:0]  cur_q;
    logic [7:0]  arm_rsp_q;
    logic [7:0]  pend_rsp_q;
    logic        rsp_v_q;
    logic [7:0]  rsp_q;
    logic        spu_q;
    logic        vpp_q;
    logic        bus_req_q;
    logic        single_q;
    logic [7:0]  wdata_q;

    logic        take;
    logic        cmd_pulse;
    logic        go_pulse;
    logic        term_hit;
    logic        end_pulse;
    logic        tmr_done;
    logic        slot_done;

    // ****************************************************************
    // decisions
    // ****************************************************************
    assign slot_done = (state_q == SPPC_ST_XFER || state_q == SPPC_ST_SBIT) && i_bus_done;
    assign cmd_pulse = state_q == SPPC_ST_IDLE && buf_v_q && !data_mode_q && sppc_is_pulse(buf_q);
    assign go_pulse  = cmd_pulse
                     || (state_q == SPPC_ST_XFER && i_bus_done && armed_q)
                     || (state_q == SPPC_ST_SBIT && i_bus_done && cur_q[`SPPC_ARM_BIT]);
    // termination is only looked for in command mode, so an infinite
    // armed pullup in data mode can never end
    assign term_hit  = state_q == SPPC_ST_PULSE && buf_v_q && buf_q == `SPPC_CMD_TERM
                     && !data_mode_q && link.dur_sel == SPPC_DUR_INFINITE;
    assign end_pulse = state_q == SPPC_ST_PULSE && (tmr_done || term_hit);
    assign take      = (state_q == SPPC_ST_IDLE && buf_v_q) || term_hit;

    // ****************************************************************
    // one-byte receive buffer
    // ****************************************************************
    // accepted only while empty, so a fill and a drain never meet
    assign link.h2d_ready = !buf_v_q;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            buf_v_q <= 1'b0;
            buf_q   <= 8'h00;
        end else if (link.h2d_valid && !buf_v_q) begin
            buf_v_q <= 1'b1;
            buf_q   <= link.h2d_data;
        end else if (take) begin
            buf_v_q <= 1'b0;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_q <= SPPC_ST_IDLE;
            cur_q   <= 8'h00;
        end else begin
            case (state_q)
                SPPC_ST_IDLE: begin
                    if (buf_v_q) begin
                        cur_q <= buf_q;
                        if (data_mode_q) begin
                            if (buf_q != `SPPC_CMD_CMD_MODE) begin
                                state_q <= SPPC_ST_XFER;
                            end
                        end else if (sppc_is_pulse(buf_q)) begin
                            state_q <= SPPC_ST_PULSE;
                        end else if (sppc_is_bit(buf_q)) begin
                            state_q <= SPPC_ST_SBIT;
                        end
                    end
                end
                SPPC_ST_XFER, SPPC_ST_SBIT: begin
                    if (i_bus_done) begin
                        state_q <= go_pulse ? SPPC_ST_PULSE : SPPC_ST_IDLE;
                    end
                end
                SPPC_ST_PULSE: begin
                    if (end_pulse) begin
                        state_q <= SPPC_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= SPPC_ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // mode and arming
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            data_mode_q <= 1'b0;
        end else if (state_q == SPPC_ST_IDLE && buf_v_q) begin
            if (data_mode_q && buf_q == `SPPC_CMD_CMD_MODE) begin
                data_mode_q <= 1'b0;
            end else if (!data_mode_q && buf_q == `SPPC_CMD_DATA_MODE) begin
                data_mode_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            armed_q   <= 1'b0;
            arm_rsp_q <= 8'h00;
        end else if (cmd_pulse) begin
            armed_q   <= buf_q[`SPPC_ARM_BIT];
            arm_rsp_q <= buf_q & `SPPC_PULSE_RSP_MASK;
        end
    end

    // ****************************************************************
    // bus slot requests
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            bus_req_q <= 1'b0;
            single_q  <= 1'b0;
            wdata_q   <= 8'h00;
        end else begin
            bus_req_q <= 1'b0;
            if (state_q == SPPC_ST_IDLE && buf_v_q) begin
                if (data_mode_q && buf_q != `SPPC_CMD_CMD_MODE) begin
                    bus_req_q <= 1'b1;
                    single_q  <= 1'b0;
                    wdata_q   <= buf_q;
                end else if (!data_mode_q && sppc_is_bit(buf_q)) begin
                    // single bit leaves the mode alone
                    bus_req_q <= 1'b1;
                    single_q  <= 1'b1;
                    wdata_q   <= {8{buf_q[`SPPC_BIT_VAL_BIT]}};
                end
            end
        end
    end

    // ****************************************************************
    // pullup and programming voltage
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            spu_q <= 1'b0;
            vpp_q <= 1'b0;
        end else if (go_pulse) begin
            // switched on in the same edge that ends the slot or the byte
            vpp_q <= cmd_pulse && buf_q[`SPPC_VPP_BIT];
            spu_q <= !(cmd_pulse && buf_q[`SPPC_VPP_BIT]);
        end else if (end_pulse) begin
            spu_q <= 1'b0;
            vpp_q <= 1'b0;
        end
    end

    sppc_dur_tmr #(
        .DUR_W (DUR_W)
    ) u_tmr (
        .i_clock    (i_clock),
        .i_rst_b    (i_rst_b),
        .i_start    (go_pulse),
        .i_stop     (term_hit),
        .i_dur_sel  (link.dur_sel),
        .i_dur_cnt  (link.dur_cnt),
        .i_load_low (i_load_low),
        .o_done     (tmr_done)
    );

    // ****************************************************************
    // responses to the host
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            pend_rsp_q <= 8'h00;
        end else if (go_pulse) begin
            pend_rsp_q <= (state_q == SPPC_ST_SBIT) ? `SPPC_SPU_RSP
                        : cmd_pulse ? (buf_q & `SPPC_PULSE_RSP_MASK) : arm_rsp_q;
        end
    end

    // the termination byte itself never answers
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            rsp_v_q <= 1'b0;
            rsp_q   <= 8'h00;
        end else begin
            rsp_v_q <= slot_done || end_pulse;
            if (state_q == SPPC_ST_XFER && i_bus_done) begin
                rsp_q <= i_bus_rdata;
            end else if (state_q == SPPC_ST_SBIT && i_bus_done) begin
                rsp_q <= {cur_q[7:2], i_bus_rdata[0], i_bus_rdata[0]};
            end else if (end_pulse) begin
                rsp_q <= pend_rsp_q;
            end
        end
    end

    assign link.d2h_valid = rsp_v_q;
    assign link.d2h_data  = rsp_q;
    assign o_bus_req      = bus_req_q;
    assign o_bus_single   = single_q;
    assign o_bus_wdata    = wdata_q;
    assign o_spu_en       = spu_q;
    assign o_vpp_en       = vpp_q;
    assign o_data_mode    = data_mode_q;
    assign o_armed        = armed_q;
endmodule

`default_nettype wire

// *** verilog/sppc_host_end.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sppc_cfg.svh"

module sppc_host_end (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_b,
    sppc_link_if.host                  link,
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [`SPPC_ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    output logic [31:0]                o_wb_dat,
    output logic                       o_wb_ack,
    output logic                       o_irq
);
    import sppc_pkg::*;

    logic                   ack_q;
    logic [31:0]            rdat_q;
    sppc_dur_t              dur_sel_q;
    logic [`SPPC_DUR_W-1:0] dur_cnt_q;
    logic                   tx_v_q;
    logic [7:0]             tx_q;
    logic [7:0]             rx_q;
    logic [`SPPC_STAT_W-1:0] stat_q;
    logic [`SPPC_STAT_W-1:0] mask_q;
    logic                   dm_q;
    logic                   arm_q;

    logic                   req;
    logic                   wr;
    logic                   tx_wr;
    logic                   tx_bad;
    logic                   sent;
    logic [`SPPC_STAT_W-1:0] set;

    // ****************************************************************
    // bus slave
    // ****************************************************************
    assign req   = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr    = i_wb_cyc && i_wb_stb && ack_q && i_wb_we && i_wb_sel[0];
    assign tx_wr = wr && i_wb_adr == `SPPC_REG_TX;
    // an armed pullup in data mode cannot be terminated, so only a
    // predefined duration may go with it
    assign tx_bad = tx_v_q || (i_wb_dat[7:0] == `SPPC_CMD_DATA_MODE && !dm_q && arm_q
                    && dur_sel_q != SPPC_DUR_PREDEF);
    assign sent  = tx_v_q && link.h2d_ready;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q  <= req;
            rdat_q <= 32'h00000000;
            if (req && !i_wb_we) begin
                case (i_wb_adr)
                    `SPPC_REG_CTRL: rdat_q <= {30'h00000000, dur_sel_q};
                    `SPPC_REG_DUR:  rdat_q <= {8'h00, dur_cnt_q};
                    `SPPC_REG_RX:   rdat_q <= {24'h000000, rx_q};
                    `SPPC_REG_STAT: rdat_q <= {23'h000000, tx_v_q, 5'h00, stat_q};
                    `SPPC_REG_MASK: rdat_q <= {29'h00000000, mask_q};
                    default:        rdat_q <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            dur_sel_q <= SPPC_DUR_PREDEF;
            dur_cnt_q <= `SPPC_DUR_RST;
            mask_q    <= '0;
        end else begin
            if (wr && i_wb_adr == `SPPC_REG_CTRL) begin
                dur_sel_q <= sppc_dur_t'(i_wb_dat[1:0]);
            end
            if (wr && i_wb_adr == `SPPC_REG_MASK) begin
                mask_q <= i_wb_dat[`SPPC_STAT_W-1:0];
            end
            if (i_wb_cyc && i_wb_stb && ack_q && i_wb_we && i_wb_adr == `SPPC_REG_DUR) begin
                for (int i = 0; i < 3; i++) begin
                    if (i_wb_sel[i]) begin
                        dur_cnt_q[8*i +: 8] <= i_wb_dat[8*i +: 8];
                    end
                end
            end
        end
    end

    // ****************************************************************
    // byte sender and mode tracking
    // ****************************************************************
    // one byte in flight at most, held until the buffer takes it
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            tx_v_q <= 1'b0;
            tx_q   <= 8'h00;
        end else if (tx_wr && !tx_bad) begin
            tx_v_q <= 1'b1;
            tx_q   <= i_wb_dat[7:0];
        end else if (sent) begin
            tx_v_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            dm_q  <= 1'b0;
            arm_q <= 1'b0;
        end else if (sent) begin
            if (dm_q && tx_q == `SPPC_CMD_CMD_MODE) begin
                dm_q <= 1'b0;
            end else if (!dm_q && tx_q == `SPPC_CMD_DATA_MODE) begin
                dm_q <= 1'b1;
            end else if (!dm_q && sppc_is_pulse(tx_q)) begin
                arm_q <= tx_q[`SPPC_ARM_BIT];
            end
        end
    end

    // ****************************************************************
    // responses and events
    // ****************************************************************
    // a termination byte is sent like any other and no reply is
    // awaited for it
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            rx_q <= 8'h00;
        end else if (link.d2h_valid) begin
            rx_q <= link.d2h_data;
        end
    end

    always_comb begin
        set                   = '0;
        set[`SPPC_ST_RSP]     = link.d2h_valid;
        set[`SPPC_ST_REFUSED] = tx_wr && tx_bad;
        set[`SPPC_ST_TX_DONE] = sent;
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            stat_q <= '0;
        end else if (wr && i_wb_adr == `SPPC_REG_STAT) begin
            stat_q <= (stat_q & ~i_wb_dat[`SPPC_STAT_W-1:0]) | set;
        end else begin
            stat_q <= stat_q | set;
        end
    end

    assign o_irq          = |(stat_q & mask_q);
    assign o_wb_ack       = ack_q;
    assign o_wb_dat       = rdat_q;
    assign link.h2d_valid = tx_v_q;
    assign link.h2d_data  = tx_q;
    assign link.dur_sel   = dur_sel_q;
    assign link.dur_cnt   = dur_cnt_q;
endmodule

`default_nettype wire

// *** test/sppc_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********
// link checker
// ********
module sppc_link_checker (
    input wire logic                i_clock,
    input wire logic                i_rst_b,
    input wire logic                h2d_valid,
    input wire logic                h2d_ready,
    input wire logic [7:0]          h2d_data,
    input wire logic                d2h_valid,
    input wire logic [7:0]          d2h_data,
    input wire sppc_pkg::sppc_dur_t dur_sel,
    input wire logic [23:0]         dur_cnt,
    input wire logic                i_spu_en,
    input wire logic                i_vpp_en,
    input wire logic                i_armed,
    input wire logic                i_data_mode,
    input wire logic                i_bus_single,
    input wire logic                i_bus_done
);
    import sppc_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    // pulse starts are only judged from a quiet command mode
    wire take = h2d_valid && h2d_ready;
    wire on   = i_spu_en || i_vpp_en;
    wire pcmd = take && !on && !i_data_mode && (h2d_data & 8'hed) == 8'hed;
    wire term = take && h2d_data == 8'hf1 && !i_data_mode;
    AST_PULSE_ON: assert property (pcmd |-> ##2 on && i_vpp_en == $past(h2d_data[4], 2))
        else $error("pulse did not start");
    AST_ARM: assert property (pcmd |-> ##2 i_armed == $past(h2d_data[1], 2))
        else $error("arm flag wrong");
    AST_TERM_END: assert property (
        term && on && dur_sel == SPPC_DUR_INFINITE |-> ##2 !on && d2h_valid && d2h_data[1:0] == 2'h0)
        else $error("termination did not end pulse");
    AST_TERM_SILENT: assert property (term && !on |=> !d2h_valid [*4])
        else $error("termination answered");
    AST_ARMED_XFER: assert property (
        i_bus_done && !i_bus_single && i_armed && i_data_mode |=> i_spu_en && d2h_valid)
        else $error("armed byte without pullup");
    AST_PLAIN_XFER: assert property (
        i_bus_done && !i_bus_single && !i_armed |=> !i_spu_en && d2h_valid)
        else $error("disarmed byte pulled up");
    AST_PREDEF_LEN: assert property (
        $rose(i_spu_en) && dur_sel == SPPC_DUR_PREDEF && dur_cnt == 24'h4 |-> i_spu_en [*4] ##1 !i_spu_en && d2h_valid)
        else $error("pullup length wrong");
    AST_BUF_TAKE: assert property (take |=> !h2d_ready)
        else $error("buffer not held");
endmodule
`default_nettype wire

// *** test/strong_pullup_pulse_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********
// bench
// ********
module strong_pullup_pulse_control_tb;
    logic        clk, rst_b, cyc, we, ack, irq, one, req, spu, vpp, dm, arm;
    logic        done = 1'b0;
    logic        load = 1'b0;
    logic [7:0]  adr, wd;
    logic [31:0] dat, wbo, rd;
    int          miscompares = 0, total_checks = 0, cycles = 0;
    sppc_link_if lk ();
    sppc_host_end sppc_host_end_i (.i_clock(clk), .i_rst_b(rst_b), .link(lk.host), .i_wb_cyc(cyc), .i_wb_stb(cyc),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat), .o_wb_dat(wbo), .o_wb_ack(ack), .o_irq(irq));
    sppc_dev_end sppc_dev_end_i (.i_clock(clk), .i_rst_b(rst_b), .link(lk.dev), .o_bus_req(req), .o_bus_single(one),
        .o_bus_wdata(wd), .i_bus_done(done), .i_bus_rdata(8'h5a), .i_load_low(load), .o_spu_en(spu), .o_vpp_en(vpp),
        .o_data_mode(dm), .o_armed(arm));
    sppc_link_checker sppc_link_checker_i (.i_clock(clk), .i_rst_b(rst_b), .h2d_valid(lk.h2d_valid),
        .h2d_ready(lk.h2d_ready), .h2d_data(lk.h2d_data), .d2h_valid(lk.d2h_valid), .d2h_data(lk.d2h_data),
        .dur_sel(lk.dur_sel), .dur_cnt(lk.dur_cnt), .i_spu_en(spu), .i_vpp_en(vpp), .i_armed(arm),
        .i_data_mode(dm), .i_bus_single(one), .i_bus_done(done));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // slot engine stand-in: each request completes one cycle later
    always @(posedge clk) begin
        done <= req;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end
    task finish_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // ends at a falling edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = wbo;
        cyc <= 1'b0;
        @(negedge clk);
    endtask
    // spacing keeps the single buffer from overrunning
    task tx(input logic [7:0] b);
        wb(1'b1, 8'h08, {24'h0, b});
        repeat (20) @(negedge clk);
    endtask
    task rx(input logic [7:0] e);
        wb(1'b0, 8'h0c, 32'h0);
        chk("rx", rd, {24'h0, e});
    endtask
    task pulses;
        logic [7:0] c [3] = '{8'hed, 8'hfd, 8'hef};
        wb(1'b0, 8'h04, 32'h0);
        chk("dur", rd, 32'h100);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'b1, 8'h04, 32'h4);
        wb(1'b1, 8'h00, 32'h2);
        foreach (c[k]) begin
            tx(c[k]);
            chk("on", {spu, vpp, arm}, {~c[k][4], c[k][4], c[k][1]});
            tx(8'hf1);
            chk("off", {spu, vpp}, 32'h0);
            rx(c[k] & 8'hfc);
        end
        tx(8'he1);
        tx(8'hf1);
        chk("refused", dm, 32'h0);
        $display("pulse test done");
    endtask
    task armed;
        wb(1'b1, 8'h00, 32'h0);
        tx(8'he1);
        tx(8'h44);
        chk("wdata", wd, 32'h44);
        chk("mode", dm, 32'h1);
        rx(8'hec);
        tx(8'he3);
        tx(8'hed);
        chk("arm", arm, 32'h0);
        tx(8'he1);
        tx(8'h44);
        rx(8'h5a);
        tx(8'he3);
        $display("armed test done");
    endtask
    task sbit;
        wb(1'b1, 8'h14, 32'h0);
        chk("irq", irq, 32'h0);
        wb(1'b1, 8'h14, 32'h1);
        chk("irq", irq, 32'h1);
        wb(1'b1, 8'h10, 32'h7);
        chk("irq", irq, 32'h0);
        tx(8'h83);
        chk("mode", dm, 32'h0);
        rx(8'hec);
        chk("irq", irq, 32'h1);
        wb(1'b1, 8'h00, 32'h2);
        tx(8'h83);
        chk("spu", spu, 32'h1);
        tx(8'hf1);
        chk("spu", spu, 32'h0);
        rx(8'hec);
        wb(1'b1, 8'h00, 32'h1);
        tx(8'hed);
        chk("spu", spu, 32'h1);
        @(posedge clk);
        load <= 1'b1;
        repeat (10) @(negedge clk);
        chk("spu", spu, 32'h0);
        rx(8'hec);
        $display("single bit test done");
    endtask
    initial begin
        rst_b = 1'b0;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h0;
        dat = 32'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        pulses();
        armed();
        sbit();
        finish_test();
    end
endmodule
`default_nettype wire
